/* File: inc/qsw_regs.svh */
// Command field positions, addresses, reset values and counts of the quad switch decoder
`ifndef QSW_REGS_SVH
`define QSW_REGS_SVH

// ============================================================
// Command word layout
`define QSW_CMD_W 16
`define QSW_WD_BIT 15
`define QSW_SEL_HI 12
`define QSW_SEL_LO 11
`define QSW_REG_HI 10
`define QSW_REG_LO 8
`define QSW_DATA_HI 4
`define QSW_DATA_LO 0

// ============================================================
// Full five-bit addresses {D12..D8}
`define QSW_ADDR_STATUS 5'h00
`define QSW_ADDR_ONOFF 5'h01
`define QSW_ADDR_CSNS 5'h09
`define QSW_ADDR_VPROT 5'h05
`define QSW_ADDR_WDOG 5'h0d
`define QSW_ADDR_NOP 5'h06

// Low three address bits of the per-output registers
`define QSW_ADDR_OCLVL 3'h2
`define QSW_ADDR_BLANK 3'h3
`define QSW_ADDR_DIRIN 3'h4

// ============================================================
// Fields, reset values, counts
`define QSW_OLDIS_BIT 3
`define QSW_RST_CFG 5'h00
`define QSW_RST_WD 1'b0
`define QSW_BITCNT_W 4
`define QSW_CHANNELS 4
`define QSW_SYNC_W 12

`endif

/* File: inc/qsw_pkg.sv */
// Types shared by the quad switch command decoder
package qsw_pkg;

    typedef logic [15:0] qsw_word_t;
    typedef logic [4:0] qsw_field_t;

    // Register kinds after address decode
    typedef enum logic [3:0] {
        QSW_REG_STATUS = 4'h0,
        QSW_REG_ONOFF  = 4'h1,
        QSW_REG_CSNS   = 4'h2,
        QSW_REG_OCLVL  = 4'h3,
        QSW_REG_BLANK  = 4'h4,
        QSW_REG_DIRIN  = 4'h5,
        QSW_REG_VPROT  = 4'h6,
        QSW_REG_WDOG   = 4'h7,
        QSW_REG_NOP    = 4'h8,
        QSW_REG_NONE   = 4'h9
    } qsw_reg_t;

endpackage

/* File: hdl/qsw_cmd_decoder.sv */
// Serial command decoder and register file of a four-channel high-side switch
`timescale 1ns/1ps
`default_nettype none
`include "qsw_regs.svh"

// Summary of operation
// - Open load detected only while output off
// - Fault latched only after gate is off
// - Fault cleared by status read once gone
// - Disable bit suppresses open-load fault flagging
// - Ground loss forces every output off
// - Sixteen-bit commands, most significant bit first
// - Bit 15 toggle is a watchdog service
// - Bits 12:11 select the output channel
// - Select code n addresses output n
// - Bits 10:8 select the command register
// - Bits 4:0 are the register data
// - Frames may carry several sixteen-bit commands
// - Frames not multiple of sixteen discarded
// - Address map decoded from bits 12:8
// - Status select only picks return data
// - Every configuration register can be read back
// - On/off data bits 3:0 drive outputs
// - No-action address changes no register
module qsw_cmd_decoder (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_n_o,
    input wire logic [3:0] ol_detect_i,
    input wire logic [3:0] gate_off_i,
    input wire logic gnd_loss_i,
    output logic [3:0] out_on_o,
    output logic [3:0] csns_en_o,
    output logic [19:0] oc_level_cfg_o,
    output logic [19:0] blank_ol_cfg_o,
    output logic [19:0] direct_in_cfg_o,
    output logic [4:0] vprot_cfg_o,
    output logic [4:0] wdog_cfg_o,
    output logic [3:0] open_load_fault_flag_o,
    output logic wd_service_o,
    output logic cmd_valid_o,
    output logic frame_err_o
);

    // ============================================================
    // Pin synchronisers
    logic [`QSW_SYNC_W-1:0] pins_raw;
    logic [`QSW_SYNC_W-1:0] meta_q;
    logic [`QSW_SYNC_W-1:0] sync_q;

    assign pins_raw = {gnd_loss_i, gate_off_i, ol_detect_i, mosi_i, cs_n_i, sclk_i};

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= 12'h006;
            sync_q <= 12'h006;
        end else begin
            meta_q <= pins_raw;
            sync_q <= meta_q;
        end
    end

    logic sclk_s;
    logic cs_n_s;
    logic mosi_s;
    logic [3:0] ol_detect_s;
    logic [3:0] gate_off_s;
    logic gnd_loss_s;

    assign sclk_s = sync_q[0];
    assign cs_n_s = sync_q[1];
    assign mosi_s = sync_q[2];
    assign ol_detect_s = sync_q[6:3];
    assign gate_off_s = sync_q[10:7];
    assign gnd_loss_s = sync_q[11];

    // ============================================================
    // Edge detection on the serial clock and select
    logic sclk_prev_q;
    logic cs_n_prev_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_prev_q <= 1'b0;
            cs_n_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_s;
            cs_n_prev_q <= cs_n_s;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;

    assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
    assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
    assign cs_fall = ~cs_n_s & cs_n_prev_q;
    assign cs_rise = cs_n_s & ~cs_n_prev_q;

    // ============================================================
    // Shift register and bit count
    qsw_pkg::qsw_word_t shift_q;
    qsw_pkg::qsw_word_t ret_word;
    logic [`QSW_BITCNT_W-1:0] bitcnt_q;
    logic any_bit_q;
    logic ret_status_q;
    logic ret_is_status;

    // Every bit shifted in pushes the oldest bit out, so in a chained
    // frame the last sixteen bits received are the ones decoded.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_q <= 16'h0000;
            bitcnt_q <= 4'h0;
            any_bit_q <= 1'b0;
            ret_status_q <= 1'b0;
        end else if (cs_fall) begin
            shift_q <= ret_word;
            bitcnt_q <= 4'h0;
            any_bit_q <= 1'b0;
            ret_status_q <= ret_is_status;
        end else if (sclk_rise) begin
            shift_q <= {shift_q[14:0], mosi_s};
            bitcnt_q <= bitcnt_q + 4'h1;
            any_bit_q <= 1'b1;
        end
    end

    // Return data changes on the falling serial edge, half a bit ahead of sampling
    logic miso_q;
    logic miso_oe_n_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            miso_q <= 1'b0;
            miso_oe_n_q <= 1'b1;
        end else begin
            miso_oe_n_q <= cs_n_s;
            if (cs_fall) begin
                miso_q <= ret_word[15];
            end else if (sclk_fall) begin
                miso_q <= shift_q[15];
            end
        end
    end

    // ============================================================
    // Frame acceptance
    logic frame_ok;

    assign frame_ok = cs_rise & any_bit_q & (bitcnt_q == 4'h0);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_valid_o <= 1'b0;
            frame_err_o <= 1'b0;
        end else begin
            cmd_valid_o <= frame_ok;
            frame_err_o <= cs_rise & ~frame_ok;
        end
    end

    // ============================================================
    // Field extraction and address decode
    logic [1:0] chan_sel;
    logic [2:0] reg_sel;
    logic [4:0] addr;
    qsw_pkg::qsw_field_t data;
    qsw_pkg::qsw_reg_t kind;

    // Bits 14, 13 and 7:5 are never looked at
    assign chan_sel = shift_q[`QSW_SEL_HI:`QSW_SEL_LO];
    assign reg_sel = shift_q[`QSW_REG_HI:`QSW_REG_LO];
    assign addr = {chan_sel, reg_sel};
    assign data = shift_q[`QSW_DATA_HI:`QSW_DATA_LO];

    always_comb begin
        kind = qsw_pkg::QSW_REG_NONE;
        if (reg_sel == `QSW_ADDR_OCLVL) begin
            kind = qsw_pkg::QSW_REG_OCLVL;
        end else if (reg_sel == `QSW_ADDR_BLANK) begin
            kind = qsw_pkg::QSW_REG_BLANK;
        end else if (reg_sel == `QSW_ADDR_DIRIN) begin
            kind = qsw_pkg::QSW_REG_DIRIN;
        end else if (addr == `QSW_ADDR_STATUS) begin
            kind = qsw_pkg::QSW_REG_STATUS;
        end else if (addr == `QSW_ADDR_ONOFF) begin
            kind = qsw_pkg::QSW_REG_ONOFF;
        end else if (addr == `QSW_ADDR_CSNS) begin
            kind = qsw_pkg::QSW_REG_CSNS;
        end else if (addr == `QSW_ADDR_VPROT) begin
            kind = qsw_pkg::QSW_REG_VPROT;
        end else if (addr == `QSW_ADDR_WDOG) begin
            kind = qsw_pkg::QSW_REG_WDOG;
        end else if (addr == `QSW_ADDR_NOP) begin
            kind = qsw_pkg::QSW_REG_NOP;
        end
    end

    // ============================================================
    // Watchdog service
    logic wd_bit_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wd_bit_q <= `QSW_RST_WD;
            wd_service_o <= 1'b0;
        end else begin
            wd_service_o <= frame_ok & (shift_q[`QSW_WD_BIT] != wd_bit_q);
            if (frame_ok) begin
                wd_bit_q <= shift_q[`QSW_WD_BIT];
            end
        end
    end

    // ============================================================
    // Global registers
    qsw_pkg::qsw_field_t status_select_q;
    qsw_pkg::qsw_field_t output_onoff_control_q;
    qsw_pkg::qsw_field_t current_sense_enable_q;
    qsw_pkg::qsw_field_t voltage_protection_config_q;
    qsw_pkg::qsw_field_t watchdog_timeout_config_q;

    // The status select only steers the next return word
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_select_q <= `QSW_RST_CFG;
        end else if (frame_ok && kind == qsw_pkg::QSW_REG_STATUS) begin
            status_select_q <= data;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            output_onoff_control_q <= `QSW_RST_CFG;
            current_sense_enable_q <= `QSW_RST_CFG;
            voltage_protection_config_q <= `QSW_RST_CFG;
            watchdog_timeout_config_q <= `QSW_RST_CFG;
        end else if (frame_ok) begin
            if (kind == qsw_pkg::QSW_REG_ONOFF) begin
                output_onoff_control_q <= data;
            end
            if (kind == qsw_pkg::QSW_REG_CSNS) begin
                current_sense_enable_q <= data;
            end
            if (kind == qsw_pkg::QSW_REG_VPROT) begin
                voltage_protection_config_q <= data;
            end
            if (kind == qsw_pkg::QSW_REG_WDOG) begin
                watchdog_timeout_config_q <= data;
            end
        end
    end

    // ============================================================
    // Per-output registers and open-load flags
    qsw_pkg::qsw_field_t oc_level_q [4];
    qsw_pkg::qsw_field_t blank_ol_q [4];
    qsw_pkg::qsw_field_t direct_in_q [4];
    logic [3:0] olf_q;
    logic [3:0] ol_cond;
    logic olf_clear;

    // A completed frame that carried the fault status out counts as its read
    assign olf_clear = frame_ok & ret_status_q;

    genvar ch;
    generate
        for (ch = 0; ch < `QSW_CHANNELS; ch = ch + 1) begin : g_chan
            logic hit;

            assign hit = frame_ok && (chan_sel == 2'(ch));

            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    oc_level_q[ch] <= `QSW_RST_CFG;
                    blank_ol_q[ch] <= `QSW_RST_CFG;
                    direct_in_q[ch] <= `QSW_RST_CFG;
                end else if (hit) begin
                    if (kind == qsw_pkg::QSW_REG_OCLVL) begin
                        oc_level_q[ch] <= data;
                    end
                    if (kind == qsw_pkg::QSW_REG_BLANK) begin
                        blank_ol_q[ch] <= data;
                    end
                    if (kind == qsw_pkg::QSW_REG_DIRIN) begin
                        direct_in_q[ch] <= data;
                    end
                end
            end

            // Detection is only meaningful once the gate has really dropped
            assign ol_cond[ch] = ~out_on_o[ch] & gate_off_s[ch] & ol_detect_s[ch];

            // A live condition holds the flag through a read: set wins over clear
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    olf_q[ch] <= 1'b0;
                end else if (blank_ol_q[ch][`QSW_OLDIS_BIT]) begin
                    olf_q[ch] <= 1'b0;
                end else begin
                    olf_q[ch] <= ol_cond[ch] | (olf_q[ch] & ~olf_clear);
                end
            end

            assign oc_level_cfg_o[ch*5 +: 5] = oc_level_q[ch];
            assign blank_ol_cfg_o[ch*5 +: 5] = blank_ol_q[ch];
            assign direct_in_cfg_o[ch*5 +: 5] = direct_in_q[ch];
        end
    endgenerate

    // ============================================================
    // Output drive
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_on_o <= 4'h0;
            csns_en_o <= 4'h0;
        end else begin
            // Ground loss overrides whatever the host commanded
            out_on_o <= output_onoff_control_q[3:0] & {4{~gnd_loss_s}};
            csns_en_o <= current_sense_enable_q[3:0];
        end
    end

    assign vprot_cfg_o = voltage_protection_config_q;
    assign wdog_cfg_o = watchdog_timeout_config_q;
    assign open_load_fault_flag_o = olf_q;
    assign miso_o = miso_q;
    assign miso_oe_n_o = miso_oe_n_q;

    // ============================================================
    // Return word selection
    // Select code mirrors the address map; code 0 returns the fault status.
    qsw_pkg::qsw_field_t ret_data;
    logic [2:0] ret_reg;
    logic [1:0] ret_ch;

    assign ret_reg = status_select_q[2:0];
    assign ret_ch = status_select_q[4:3];
    assign ret_is_status = (status_select_q == `QSW_ADDR_STATUS);

    always_comb begin
        ret_data = 5'h00;
        if (ret_reg == `QSW_ADDR_OCLVL) begin
            ret_data = oc_level_q[ret_ch];
        end else if (ret_reg == `QSW_ADDR_BLANK) begin
            ret_data = blank_ol_q[ret_ch];
        end else if (ret_reg == `QSW_ADDR_DIRIN) begin
            ret_data = direct_in_q[ret_ch];
        end else if (status_select_q == `QSW_ADDR_STATUS) begin
            ret_data = {1'b0, olf_q};
        end else if (status_select_q == `QSW_ADDR_ONOFF) begin
            ret_data = output_onoff_control_q;
        end else if (status_select_q == `QSW_ADDR_CSNS) begin
            ret_data = current_sense_enable_q;
        end else if (status_select_q == `QSW_ADDR_VPROT) begin
            ret_data = voltage_protection_config_q;
        end else if (status_select_q == `QSW_ADDR_WDOG) begin
            ret_data = watchdog_timeout_config_q;
        end
    end

    assign ret_word = {wd_bit_q, 2'b00, status_select_q, 3'b000, ret_data};

endmodule
`default_nettype wire

/* File: testbench/qsw_checker.sv */
// Port-level assertions for the quad switch command decoder
`timescale 1ns/1ps
`default_nettype none
module qsw_checker (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    input wire logic miso_o,
    input wire logic miso_oe_n_o,
    input wire logic [3:0] ol_detect_i,
    input wire logic [3:0] gate_off_i,
    input wire logic gnd_loss_i,
    input wire logic [3:0] out_on_o,
    input wire logic [3:0] csns_en_o,
    input wire logic [19:0] oc_level_cfg_o,
    input wire logic [19:0] blank_ol_cfg_o,
    input wire logic [19:0] direct_in_cfg_o,
    input wire logic [4:0] vprot_cfg_o,
    input wire logic [4:0] wdog_cfg_o,
    input wire logic [3:0] open_load_fault_flag_o,
    input wire logic wd_service_o,
    input wire logic cmd_valid_o,
    input wire logic frame_err_o
);
    logic [3:0] dis;
    assign dis = {blank_ol_cfg_o[18], blank_ol_cfg_o[13], blank_ol_cfg_o[8], blank_ol_cfg_o[3]};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ============================================================
    // Outputs and faults
    a_gnd_forces_off: assert property (gnd_loss_i [*4] |-> out_on_o == 4'h0)
        else $error("output on in ground loss");
    a_flag_only_off: assert property ((open_load_fault_flag_o & ~$past(open_load_fault_flag_o)
        & $past(out_on_o)) == 4'h0) else $error("fault set while on");
    // Input synchroniser may take two or three cycles
    a_flag_gate_off: assert property (((open_load_fault_flag_o & ~$past(open_load_fault_flag_o))
        & ~($past(gate_off_i, 2) | $past(gate_off_i, 3))) == 4'h0)
        else $error("fault before gate off");
    a_disable_masks: assert property ((open_load_fault_flag_o & dis & $past(dis)) == 4'h0)
        else $error("fault while disabled");
    // ============================================================
    // Framing and registers
    a_err_no_write: assert property (frame_err_o |-> !cmd_valid_o && $stable(csns_en_o)
        && $stable(blank_ol_cfg_o) && $stable(vprot_cfg_o) && $stable(wdog_cfg_o))
        else $error("bad frame changed state");
    a_regs_only_valid: assert property (!cmd_valid_o |-> $stable(oc_level_cfg_o)
        && $stable(direct_in_cfg_o) && $stable(blank_ol_cfg_o))
        else $error("register moved without command");
    // Sense enables pass one more flop, so they move a cycle after the pulse
    a_csns_one_late: assert property (!$past(cmd_valid_o) |-> $stable(csns_en_o))
        else $error("sense enable moved without command");
    a_wd_with_valid: assert property (wd_service_o |-> cmd_valid_o)
        else $error("watchdog pulse without command");
    a_end_at_cs: assert property ((cmd_valid_o || frame_err_o) |-> cs_n_i && $past(cs_n_i, 2))
        else $error("frame ended with select low");
    a_miso_release: assert property (cs_n_i [*4] |-> miso_oe_n_o)
        else $error("serial output driven outside frame");
endmodule
bind qsw_cmd_decoder qsw_checker qsw_checker_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .mosi_i(mosi_i),
    .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o), .ol_detect_i(ol_detect_i),
    .gate_off_i(gate_off_i), .gnd_loss_i(gnd_loss_i), .out_on_o(out_on_o),
    .csns_en_o(csns_en_o), .oc_level_cfg_o(oc_level_cfg_o), .blank_ol_cfg_o(blank_ol_cfg_o),
    .direct_in_cfg_o(direct_in_cfg_o), .vprot_cfg_o(vprot_cfg_o), .wdog_cfg_o(wdog_cfg_o),
    .open_load_fault_flag_o(open_load_fault_flag_o), .wd_service_o(wd_service_o),
    .cmd_valid_o(cmd_valid_o), .frame_err_o(frame_err_o)
);
`default_nettype wire

/* File: testbench/qsw_host_model.sv */
// Host serial controller model driving command frames
`timescale 1ns/1ps
`default_nettype none
module qsw_host_model (
    input wire logic clk_i,
    input wire logic miso_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // Four falling clock edges give an 80 ns half period, so a 160 ns serial period
    task automatic half();
        repeat (4) @(negedge clk_i);
    endtask
    task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
        r = 32'h0;
        cs_n_o = 1'b0;
        half();
        for (int i = n - 1; i >= 0; i--) begin
            mosi_o = w[i];
            half();
            sclk_o = 1'b1;
            r = {r[30:0], miso_i};
            half();
            sclk_o = 1'b0;
        end
        cs_n_o = 1'b1;
        // Released line must not keep showing the last bit
        mosi_o = ~mosi_o;
        repeat (8) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

/* File: testbench/qsw_cmd_decoder_bench.sv */
// Self-checking bench for the quad switch command decoder
`timescale 1ns/1ps
`default_nettype none
module qsw_cmd_decoder_bench;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sclk, cs_n, mosi, miso, oe_n, wds, vld, fer;
    logic gnd = 1'b0;
    logic [3:0] old = 4'h0;
    logic [3:0] gof = 4'h0;
    logic [3:0] oon, cse, open_load_fault_flag, efl;
    logic [19:0] occ, blc, dic;
    logic [4:0] vpc, wdc, a, d, m;
    int err_count = 0;
    int comparisons = 0;
    int nv = 0, nf = 0, nw = 0, ev = 0, ef = 0, ew = 0;
    logic [4:0] onoff = '0, csns = '0, vp = '0, wdg = '0;
    logic [3:0][4:0] oc = '0, bl = '0, di = '0;
    logic wd = 1'b0;
    logic [15:0] r;
    logic [31:0] rr, w1;
    logic [4:0] wa [7] = '{5'h01, 5'h09, 5'h05, 5'h0d, 5'h02, 5'h03, 5'h04};
    int bad [4] = '{0, 1, 15, 17};
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (vld === 1'b1) nv++;
        if (fer === 1'b1) nf++;
        if (wds === 1'b1) nw++;
    end
    qsw_cmd_decoder qsw_cmd_decoder_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
        .miso_o(miso), .miso_oe_n_o(oe_n), .ol_detect_i(old), .gate_off_i(gof),
        .gnd_loss_i(gnd), .out_on_o(oon), .csns_en_o(cse), .oc_level_cfg_o(occ),
        .blank_ol_cfg_o(blc), .direct_in_cfg_o(dic), .vprot_cfg_o(vpc), .wdog_cfg_o(wdc),
        .open_load_fault_flag_o(open_load_fault_flag), .wd_service_o(wds), .cmd_valid_o(vld),
        .frame_err_o(fer)
    );
    qsw_host_model qsw_host_model_i (
        .clk_i(clk_i), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi)
    );
    // ============================================================
    // Checking and expectation helpers
    task automatic check(input logic [19:0] s, input logic [19:0] e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic tally_and_finish();
        $display("counts: %0d compares, %0d mismatches", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    function automatic logic [4:0] exp_rd(input logic [4:0] x);
        case (x)
            5'h01: return onoff;
            5'h09: return csns;
            5'h05: return vp;
            5'h0d: return wdg;
            default: case (x[2:0])
                3'h2: return oc[x[4:3]];
                3'h3: return bl[x[4:3]];
                default: return di[x[4:3]];
            endcase
        endcase
    endfunction
    task automatic upd(input logic [4:0] x, input logic [4:0] v);
        case (x)
            5'h01: onoff = v;
            5'h09: csns = v;
            5'h05: vp = v;
            5'h0d: wdg = v;
            default: case (x[2:0])
                3'h2: oc[x[4:3]] = v;
                3'h3: bl[x[4:3]] = v;
                3'h4: di[x[4:3]] = v;
                default: ;
            endcase
        endcase
    endtask
    task automatic check_all();
        check(oon, gnd ? 4'h0 : onoff[3:0]);
        check(cse, csns[3:0]);
        check(occ, oc);
        check(blc, bl);
        check(dic, di);
        check({vpc, wdc}, {vp, wdg});
        check(open_load_fault_flag, efl);
        check(20'(nv), 20'(ev));
        check(20'(nf), 20'(ef));
        check(20'(nw), 20'(ew));
        check(oe_n, 1'b1);
    endtask
    task automatic cmd(input logic [4:0] x, input logic [4:0] v, input bit tog);
        logic [4:0] j;
        j = 5'($urandom);
        if (tog) wd = ~wd;
        qsw_host_model_i.xfer({16'h0, wd, j[1:0], x, j[4:2], v}, 16, rr);
        r = rr[15:0];
        ew += tog;
        ev++;
        upd(x, v);
    endtask
    initial begin
        #1000000;
        $display("ERROR t=%0t run did not finish", $time);
        err_count++;
        tally_and_finish();
    end
    // ============================================================
    // Main sequence
    initial begin
        void'($urandom(32'hd059));
        efl = 4'h0;
        repeat (10) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        for (int k = 0; k < 12; k++) begin
            a = wa[$urandom % 7];
            if (a inside {5'h02, 5'h03, 5'h04}) a[4:3] = 2'($urandom);
            d = 5'($urandom);
            cmd(a, d, 1'b1);
            cmd(5'h00, a, 1'b1);
            cmd(5'h06, 5'h00, 1'b1);
            check_all();
            m = (a == 5'h01 || a == 5'h09) ? 5'h0f : 5'h1f;
            check(r[12:0] & {5'h1f, 3'h0, m}, {a, 3'h0, exp_rd(a) & m});
        end
        $display("test register writes done");
        foreach (bad[i]) begin
            qsw_host_model_i.xfer($urandom, bad[i], rr);
            ef++;
            check_all();
        end
        w1 = $urandom;
        wd = ~wd;
        ew++;
        ev++;
        qsw_host_model_i.xfer({w1[15:0], wd, 2'b00, 5'h01, 3'h0, 5'h0a}, 32, rr);
        upd(5'h01, 5'h0a);
        check(rr[15:0], w1[15:0]);
        check_all();
        cmd(5'h06, 5'h00, 1'b0);
        check_all();
        cmd(5'h11, 5'h1f, 1'b1);
        check_all();
        $display("test framing done");
        old = 4'hf;
        for (int c = 0; c < 4; c++) cmd({2'(c), 3'h3}, 5'h00, 1'b1);
        cmd(5'h01, 5'h05, 1'b1);
        check_all();
        gof = 4'hf;
        efl = 4'ha;
        repeat (8) @(negedge clk_i);
        check_all();
        cmd(5'h1b, 5'h08, 1'b1);
        efl = 4'h2;
        check_all();
        old = 4'h0;
        repeat (8) @(negedge clk_i);
        check_all();
        cmd(5'h00, 5'h00, 1'b1);
        cmd(5'h06, 5'h00, 1'b1);
        check(r[12:0], {5'h00, 3'h0, 5'h02});
        efl = 4'h0;
        check_all();
        $display("test open load done");
        cmd(5'h01, 5'h0f, 1'b1);
        gnd = 1'b1;
        repeat (8) @(negedge clk_i);
        check_all();
        gnd = 1'b0;
        repeat (8) @(negedge clk_i);
        check_all();
        $display("test ground loss done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
